// file: flash_cmd_regs.vh
// constants for the serial flash erase/program command sequencer
// Behaviour
// - 4K sector wipe sets sector to ones
// - wipes and writes need write_allow_latch set
// - address wipes end exactly after address byte
// - sector chosen by address bits from A12 up
// - opcode as 8 SPI or 2 QPI clocks
// - busy flag from rise until done, clears latch
// - protected targets are never executed
// - 32K block wipe sets block to ones
// - 64K block wipe sets block to ones
// - whole array wipe carries no address
// - level mode: whole wipe only if bits zero
// - sector mode: whole wipe skips locked sectors
// - page write takes 1 to 256 bytes
// - over 256 bytes keeps last 256 only
// - low address byte starts, wraps in page
// - page write ends exactly after data byte
// - quad page write needs quad_io_allow too
// - factory mode refuses suspend
// - factory mode cleared on reset or completion
// - fail flags set on failure, cleared success
// - factory status reads ff active, else 00
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH
`define OP_WRITE_ALLOW 8'h06
`define OP_FAST_MFG 8'h68
`define OP_SECTOR_WIPE 8'h20
`define OP_HALF_WIPE 8'h52
`define OP_LARGE_WIPE 8'hd8
`define OP_WHOLE_WIPE 8'h60
`define OP_PAGE_WRITE 8'h02
`define OP_QUAD_PAGE_WRITE 8'h38
`define OP_SUSPEND 8'hb0
`define CORE_CLK_MHZ 100
`define SECTOR_WIPE_TIME_US 30
`define HALF_WIPE_TIME_US 150
`define LARGE_WIPE_TIME_US 250
`define WHOLE_WIPE_TIME_US 2000
`define PAGE_WRITE_TIME_US 10
`define SECTOR_SHIFT 12
`define FIFO_DEPTH 4
`define FMODE_ON 8'hff
`define FMODE_OFF 8'h00
`endif

// file: bit_sync.v
// two flip-flop synchroniser for one level
`default_nettype none
module bit_sync
#(
	parameter [0:0] RST_VAL = 1'b0
)
(
	input wire i_core_clk,
	input wire i_reset_n,
	input wire i_async,
	output wire o_sync
);
	reg meta_r; // first stage, read only by the second
	reg sync_r; // second stage, safe to use
	// first stage may go metastable, so nothing else looks at it
	always @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			// reset to the pin's idle level so no false edge follows
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end
		else
		begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end
	assign o_sync = sync_r;
endmodule
`default_nettype wire

// file: byte_fifo.v
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module byte_fifo
#(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW = 2
)
(
	input wire i_core_clk,
	input wire i_reset_n,
	input wire i_flush,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
	reg [AW-1:0] wr_ptr_r; // write index
	reg [AW-1:0] rd_ptr_r; // read index
	reg [AW:0] count_r; // words held
	wire push;
	wire pop;
	assign o_in_ready = (count_r != DEPTH[AW:0]);
	assign o_out_valid = (count_r != {(AW+1){1'b0}});
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_ptr_r];
	// storage write, no reset needed on data
	always @(posedge i_core_clk)
	begin
		if (push)
			mem[wr_ptr_r] <= i_in_data;
	end
	// pointers and fill level
	always @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else if (i_flush)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: flash_cmd_seq.v
// serial flash erase/program command sequencer, device side
`include "flash_cmd_regs.vh"
`default_nettype none
module flash_cmd_seq
#(
	parameter [7:0] OP_WRITE_ALLOW = `OP_WRITE_ALLOW,
	parameter [7:0] OP_FAST_MFG = `OP_FAST_MFG,
	parameter [7:0] OP_SECTOR_WIPE = `OP_SECTOR_WIPE,
	parameter [7:0] OP_HALF_WIPE = `OP_HALF_WIPE,
	parameter [7:0] OP_LARGE_WIPE = `OP_LARGE_WIPE,
	parameter [7:0] OP_WHOLE_WIPE = `OP_WHOLE_WIPE,
	parameter [7:0] OP_PAGE_WRITE = `OP_PAGE_WRITE,
	parameter [7:0] OP_QUAD_PAGE_WRITE = `OP_QUAD_PAGE_WRITE,
	parameter [7:0] OP_SUSPEND = `OP_SUSPEND,
	parameter [31:0] SECTOR_WIPE_CYC =
		`SECTOR_WIPE_TIME_US * `CORE_CLK_MHZ,
	parameter [31:0] HALF_WIPE_CYC = `HALF_WIPE_TIME_US * `CORE_CLK_MHZ,
	parameter [31:0] LARGE_WIPE_CYC = `LARGE_WIPE_TIME_US * `CORE_CLK_MHZ,
	parameter [31:0] WHOLE_WIPE_CYC = `WHOLE_WIPE_TIME_US * `CORE_CLK_MHZ,
	parameter [31:0] PAGE_WRITE_CYC = `PAGE_WRITE_TIME_US * `CORE_CLK_MHZ
)
(
	input wire i_core_clk,
	input wire i_reset_n,
	input wire i_cs_n,
	input wire i_sclk,
	input wire [3:0] i_quad_lines,
	input wire i_qpi_mode,
	input wire i_quad_io_allow,
	input wire i_protect_scheme_choice,
	input wire [3:0] i_level_protect_bits,
	input wire [255:0] i_sector_lock_bits,
	input wire i_soft_reset,
	input wire i_array_fail,
	output reg o_write_allow_latch,
	output reg o_op_in_progress_flag,
	output reg o_wipe_fail_flag,
	output reg o_write_fail_flag,
	output reg [7:0] o_fmode_status,
	output reg o_suspend_refused,
	output reg o_wipe_start,
	output reg [2:0] o_wipe_kind,
	output reg [23:0] o_wipe_addr,
	output reg [255:0] o_wipe_skip_mask,
	output wire o_wdata_valid,
	input wire i_wdata_ready,
	output wire [15:0] o_wdata,
	output reg o_write_start,
	output reg o_write_done
);
	// kinds of operation reported on o_wipe_kind
	localparam [2:0] K_NONE = 3'h0;
	localparam [2:0] K_SECTOR = 3'h1;
	localparam [2:0] K_HALF = 3'h2;
	localparam [2:0] K_LARGE = 3'h3;
	localparam [2:0] K_WHOLE = 3'h4;
	localparam [2:0] K_PAGE = 3'h5;
	// frame phases
	localparam [1:0] P_OPC = 2'h0;
	localparam [1:0] P_ADDR = 2'h1;
	localparam [1:0] P_DATA = 2'h2;
	localparam [1:0] P_SKIP = 2'h3;
	// busy states
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_BUSY = 2'h1;
	localparam [1:0] S_DRAIN = 2'h2;

	wire cs_n_s; // synchronised chip select
	wire sclk_s; // synchronised link clock
	wire [3:0] quad_s; // synchronised data lines
	reg sclk_d_r; // previous link clock for edge find
	reg cs_d_r; // previous chip select for rise find
	wire sclk_rise;
	wire cs_rise;
	reg [1:0] phase_r; // which part of the frame
	reg [7:0] opc_r; // opcode being shifted
	reg [23:0] addr_r; // address being shifted
	reg [7:0] sh_r; // data byte being shifted
	reg [5:0] bits_r; // bits taken in current phase
	reg wide_r; // address/data on four lines
	reg [7:0] cur_op_r; // opcode of this frame
	reg [8:0] nbytes_r; // data bytes received, saturating
	reg [7:0] pg_ptr_r; // next byte slot within the page
	reg [7:0] page_mem [0:255]; // page buffer
	reg [255:0] pg_vld_r; // slots written this frame
	reg fmode_r; // factory mode armed
	reg [1:0] st_r; // busy state
	reg [31:0] tmr_r; // self-timed countdown
	reg [2:0] kind_r; // operation in progress
	reg fail_r; // array reported a fault
	reg [8:0] drain_r; // page slot being sent to the array
	wire [3:0] bin;
	wire [5:0] bstep;
	wire [5:0] bits_n;
	wire [7:0] opc_n;
	wire [23:0] addr_n;
	wire [7:0] sh_n;
	wire op_ok;
	wire [2:0] op_kind;
	reg [31:0] op_cyc;
	wire prot;
	wire lvl_clear;
	wire fifo_in_ready;
	wire fifo_in_valid;
	wire lock_hit; // target block holds a locked sector
	wire [255:0] skip_mask; // sectors a whole wipe leaves alone

	genvar g;
	// pins come from the host clock domain, so all pass two flops
	// chip select idles high, so its flops reset high: no false rise
	bit_sync #(.RST_VAL(1'b1)) u_sync_cs (.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n), .i_async(i_cs_n), .o_sync(cs_n_s));
	bit_sync u_sync_ck (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_async(i_sclk), .o_sync(sclk_s));
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_qs
			bit_sync u_sync_q (.i_core_clk(i_core_clk),
				.i_reset_n(i_reset_n), .i_async(i_quad_lines[g]),
				.o_sync(quad_s[g]));
		end
	endgenerate

	assign sclk_rise = sclk_s && !sclk_d_r && !cs_n_s;
	assign cs_rise = cs_n_s && !cs_d_r;
	// in single-line phases only line 0 counts
	assign bin = (phase_r == P_OPC) ? (i_qpi_mode ? quad_s : {3'h0, quad_s[0]})
		: (wide_r ? quad_s : {3'h0, quad_s[0]});
	assign bstep = ((phase_r == P_OPC) ? i_qpi_mode : wide_r) ? 6'd4 : 6'd1;
	assign bits_n = bits_r + bstep;
	assign opc_n = (bstep == 6'd4) ? {opc_r[3:0], bin} : {opc_r[6:0], bin[0]};
	assign addr_n = (bstep == 6'd4) ? {addr_r[19:0], bin}
		: {addr_r[22:0], bin[0]};
	assign sh_n = (bstep == 6'd4) ? {sh_r[3:0], bin} : {sh_r[6:0], bin[0]};

	// decode opcode table
	assign op_kind = (cur_op_r == OP_SECTOR_WIPE) ? K_SECTOR :
		(cur_op_r == OP_HALF_WIPE) ? K_HALF :
		(cur_op_r == OP_LARGE_WIPE) ? K_LARGE :
		(cur_op_r == OP_WHOLE_WIPE) ? K_WHOLE :
		((cur_op_r == OP_PAGE_WRITE) ||
		(cur_op_r == OP_QUAD_PAGE_WRITE)) ? K_PAGE : K_NONE;
	// frame legal only if chip select rose on the right boundary
	assign op_ok = (op_kind == K_WHOLE) ? (phase_r == P_ADDR && bits_r == 6'd0)
		: (op_kind == K_PAGE) ? (phase_r == P_DATA && bits_r == 6'd0 &&
			nbytes_r != 9'd0)
		: (phase_r == P_DATA && bits_r == 6'd0 &&
			nbytes_r == 9'd0);
	assign lvl_clear = (i_level_protect_bits == 4'h0);
	// lock mode: a locked 4K sector anywhere in the target block protects
	assign lock_hit = (op_kind == K_LARGE) ?
		(i_sector_lock_bits[{addr_r[19:16], 4'h0} +: 16] != 16'h0) :
		(op_kind == K_HALF) ?
		(i_sector_lock_bits[{addr_r[19:15], 3'h0} +: 8] != 8'h0) :
		i_sector_lock_bits[addr_r[`SECTOR_SHIFT+7:`SECTOR_SHIFT]];
	// level mode: any nonzero level bit protects everything
	assign prot = (op_kind == K_WHOLE) ?
		(!i_protect_scheme_choice && !lvl_clear) :
		(i_protect_scheme_choice ? lock_hit : !lvl_clear);
	// an end 64K block with any locked sector is skipped as a whole
	assign skip_mask = i_sector_lock_bits |
		{{16{|i_sector_lock_bits[255:240]}}, 224'h0,
		{16{|i_sector_lock_bits[15:0]}}};

	// pick cycle count of the self-timed operation
	always @*
	begin
		case (op_kind)
			K_SECTOR: op_cyc = SECTOR_WIPE_CYC;
			K_HALF: op_cyc = HALF_WIPE_CYC;
			K_LARGE: op_cyc = LARGE_WIPE_CYC;
			K_WHOLE: op_cyc = WHOLE_WIPE_CYC;
			default: op_cyc = PAGE_WRITE_CYC;
		endcase
	end

	// shift in opcode, address and data on link clock edges
	always @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b1;
			phase_r <= P_OPC;
			opc_r <= 8'h00;
			addr_r <= 24'h000000;
			sh_r <= 8'h00;
			bits_r <= 6'd0;
			wide_r <= 1'b0;
			cur_op_r <= 8'h00;
			nbytes_r <= 9'd0;
			pg_ptr_r <= 8'h00;
			pg_vld_r <= 256'h0;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			cs_d_r <= cs_n_s;
			if (cs_n_s)
			begin
				// between frames: ready for a new opcode
				phase_r <= P_OPC;
				bits_r <= 6'd0;
				if (st_r == S_IDLE)
					pg_vld_r <= (cs_rise) ? pg_vld_r : 256'h0;
			end
			else if (sclk_rise)
			begin
				case (phase_r)
					P_OPC:
					begin
						opc_r <= opc_n;
						if (bits_n == 6'd8)
						begin
							cur_op_r <= opc_n;
							bits_r <= 6'd0;
							nbytes_r <= 9'd0;
							wide_r <= i_qpi_mode ||
								(opc_n == OP_QUAD_PAGE_WRITE);
							phase_r <= (st_r != S_IDLE) ? P_SKIP : P_ADDR;
						end
						else
							bits_r <= bits_n;
					end
					P_ADDR:
					begin
						addr_r <= addr_n;
						if (bits_n == 6'd24)
						begin
							bits_r <= 6'd0;
							pg_ptr_r <= addr_n[7:0];
							phase_r <= P_DATA;
						end
						else
							bits_r <= bits_n;
					end
					P_DATA:
					begin
						sh_r <= sh_n;
						if (bits_n == 6'd8)
						begin
							bits_r <= 6'd0;
							// slot reused when wrapping, so last 256 win
							page_mem[pg_ptr_r] <= sh_n;
							pg_vld_r[pg_ptr_r] <= 1'b1;
							pg_ptr_r <= pg_ptr_r + 8'h01;
							if (nbytes_r != 9'h1ff)
								nbytes_r <= nbytes_r + 9'd1;
						end
						else
							bits_r <= bits_n;
					end
					default: bits_r <= 6'd0;
				endcase
			end
		end
	end

	// latch, factory mode, busy timer and status flags
	always @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_write_allow_latch <= 1'b0;
			o_op_in_progress_flag <= 1'b0;
			o_wipe_fail_flag <= 1'b0;
			o_write_fail_flag <= 1'b0;
			o_fmode_status <= `FMODE_OFF;
			o_suspend_refused <= 1'b0;
			o_wipe_start <= 1'b0;
			o_wipe_kind <= K_NONE;
			o_wipe_addr <= 24'h000000;
			o_wipe_skip_mask <= 256'h0;
			o_write_start <= 1'b0;
			o_write_done <= 1'b0;
			fmode_r <= 1'b0;
			st_r <= S_IDLE;
			tmr_r <= 32'd0;
			kind_r <= K_NONE;
			fail_r <= 1'b0;
			drain_r <= 9'd0;
		end
		else
		begin
			o_wipe_start <= 1'b0;
			o_write_start <= 1'b0;
			o_write_done <= 1'b0;
			o_suspend_refused <= 1'b0;
			o_fmode_status <= fmode_r ? `FMODE_ON : `FMODE_OFF;
			if (i_soft_reset)
				fmode_r <= 1'b0;
			case (st_r)
				S_IDLE:
				begin
					if (cs_rise && phase_r == P_ADDR && bits_r == 6'd0)
					begin
						// opcode-only frames
						if (cur_op_r == OP_WRITE_ALLOW)
							o_write_allow_latch <= 1'b1;
						else if (cur_op_r == OP_FAST_MFG &&
							o_write_allow_latch)
							fmode_r <= 1'b1;
						else if (cur_op_r == OP_SUSPEND && fmode_r)
							o_suspend_refused <= 1'b1;
					end
					if (cs_rise && op_kind != K_NONE && op_ok &&
						o_write_allow_latch &&
						(cur_op_r != OP_QUAD_PAGE_WRITE ||
						i_quad_io_allow))
					begin
						if (prot)
						begin
							// protected target: flag only, no cycle
							if (op_kind == K_PAGE)
								o_write_fail_flag <= 1'b1;
							else
								o_wipe_fail_flag <= 1'b1;
						end
						else
						begin
							st_r <= S_BUSY;
							o_op_in_progress_flag <= 1'b1;
							tmr_r <= op_cyc;
							kind_r <= op_kind;
							fail_r <= 1'b0;
							o_wipe_kind <= op_kind;
							o_wipe_addr <= addr_r;
							o_wipe_skip_mask <= (op_kind == K_WHOLE &&
								i_protect_scheme_choice) ?
								skip_mask : 256'h0;
							if (op_kind == K_PAGE)
								o_write_start <= 1'b1;
							else
								o_wipe_start <= 1'b1;
						end
					end
				end
				S_BUSY:
				begin
					if (i_array_fail)
						fail_r <= 1'b1;
					if (tmr_r > 32'd1)
						tmr_r <= tmr_r - 32'd1;
					else if (kind_r == K_PAGE)
					begin
						st_r <= S_DRAIN;
						drain_r <= 9'd0;
					end
					else
					begin
						// cycle over: flag and latch drop together
						st_r <= S_IDLE;
						o_op_in_progress_flag <= 1'b0;
						o_write_allow_latch <= 1'b0;
						o_wipe_fail_flag <= fail_r || i_array_fail;
						fmode_r <= 1'b0;
					end
				end
				S_DRAIN:
				begin
					if (fifo_in_ready || !pg_vld_r[drain_r[7:0]])
						drain_r <= drain_r + 9'd1;
					if (drain_r == 9'd256)
					begin
						st_r <= S_IDLE;
						o_op_in_progress_flag <= 1'b0;
						o_write_allow_latch <= 1'b0;
						o_write_fail_flag <= fail_r;
						o_write_done <= 1'b1;
						fmode_r <= 1'b0;
					end
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// page bytes to the array as {offset, byte}; slow array stalls drain
	assign fifo_in_valid = (st_r == S_DRAIN) && !drain_r[8] &&
		pg_vld_r[drain_r[7:0]];
	byte_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH), .AW(2)) u_fifo
	(
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_flush(1'b0),
		.i_in_valid(fifo_in_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data({drain_r[7:0], page_mem[drain_r[7:0]]}),
		.o_out_valid(o_wdata_valid),
		.i_out_ready(i_wdata_ready),
		.o_out_data(o_wdata)
	);
endmodule
`default_nettype wire

// file: flash_cmd_seq_checker.sv
// port assertions for the erase/program command sequencer
`default_nettype none
module flash_cmd_seq_checker
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_cs_n,
	input wire logic i_protect_scheme_choice,
	input wire logic [3:0] i_level_protect_bits,
	input wire logic [255:0] i_sector_lock_bits,
	input wire logic o_write_allow_latch,
	input wire logic o_op_in_progress_flag,
	input wire logic [7:0] o_fmode_status,
	input wire logic o_suspend_refused,
	input wire logic o_wipe_start,
	input wire logic [2:0] o_wipe_kind,
	input wire logic [23:0] o_wipe_addr,
	input wire logic [255:0] o_wipe_skip_mask,
	input wire logic o_write_start
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	wire go = o_wipe_start || o_write_start; // any cycle launched
	wire busy = o_op_in_progress_flag; // short alias
	wire sch = i_protect_scheme_choice; // 1: lock bits govern
	// a launched cycle shows busy at once
	property p_start_busy; go |-> busy; endproperty
	a_start_busy: assert property (p_start_busy) else $error("start idle");
	// busy only rises with the latch still set
	property p_latch; $rose(busy) |-> o_write_allow_latch; endproperty
	a_latch: assert property (p_latch) else $error("no latch");
	// latch drops in the same cycle as busy
	property p_clear; $fell(busy) |-> !o_write_allow_latch; endproperty
	a_clear: assert property (p_clear) else $error("latch kept");
	// launch only after chip select has risen
	property p_rise; go |-> i_cs_n && $past(i_cs_n); endproperty
	a_rise: assert property (p_rise) else $error("cs low");
	// page writes use kind 5, wipes kinds 1 to 4
	property p_kind;
		go |-> (o_write_start ? o_wipe_kind == 3'd5 :
			o_wipe_kind inside {[3'd1:3'd4]});
	endproperty
	a_kind: assert property (p_kind) else $error("bad kind");
	// level scheme: any nonzero bit blocks every launch
	property p_level; go && !sch |-> i_level_protect_bits == 4'h0; endproperty
	a_level: assert property (p_level) else $error("level");
	// lock scheme: a locked target sector never launches
	property p_lock;
		go && sch && o_wipe_kind != 3'd4 |->
			!i_sector_lock_bits[o_wipe_addr[19:12]];
	endproperty
	a_lock: assert property (p_lock) else $error("locked");
	// lock scheme: a 64K wipe never covers a locked sector
	property p_blk;
		go && sch && o_wipe_kind == 3'd3 |->
			i_sector_lock_bits[{o_wipe_addr[19:16], 4'h0} +: 16] == 16'h0;
	endproperty
	a_blk: assert property (p_blk) else $error("block locked");
	// whole wipe skips at least every locked sector
	property p_mask;
		o_wipe_start && sch && o_wipe_kind == 3'd4 |->
			(o_wipe_skip_mask & i_sector_lock_bits) == i_sector_lock_bits;
	endproperty
	a_mask: assert property (p_mask) else $error("mask");
	// busy holds a while, then ends within a bound
	property p_len; $rose(busy) |-> busy [*8] ##[1:1000] !busy; endproperty
	a_len: assert property (p_len) else $error("busy len");
	// factory state cleared as the cycle completes
	property p_fm; $fell(busy) |-> ##[0:2] o_fmode_status == 8'h00; endproperty
	a_fm: assert property (p_fm) else $error("fmode kept");
	// suspend refusal only in factory mode
	property p_susp; o_suspend_refused |-> o_fmode_status == 8'hff; endproperty
	a_susp: assert property (p_susp) else $error("suspend");
	c_whole: cover property (o_wipe_start && o_wipe_kind == 3'd4);
	c_page: cover property (o_write_start);
	c_susp: cover property (o_suspend_refused);
endmodule
bind flash_cmd_seq flash_cmd_seq_checker i_chk (.i_core_clk, .i_reset_n,
	.i_cs_n, .i_protect_scheme_choice, .i_level_protect_bits,
	.i_sector_lock_bits, .o_write_allow_latch, .o_op_in_progress_flag,
	.o_fmode_status, .o_suspend_refused, .o_wipe_start, .o_wipe_kind,
	.o_wipe_addr, .o_wipe_skip_mask, .o_write_start);
`default_nettype wire

// file: host_spi_model.sv
// host model: frames opcode, address and data on the link pins
`default_nettype none
module host_spi_model
(
	output var logic o_cs_n,
	output var logic o_sclk,
	output var logic [3:0] o_lines
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] last_r; // last value driven, inverted once released
	// one link clock: lines set while low, taken on the rise
	task automatic put(input logic [3:0] v);
		o_lines = v;
		last_r = v;
		#40 o_sclk = 1'b1;
		#40 o_sclk = 1'b0;
	endtask
	// a byte msb first, on one line or as two nibbles
	task automatic send(input logic [7:0] b, input logic wide);
		int i;
		if (wide)
		begin
			put(b[7:4]); // four lines per clock
			put(b[3:0]);
		end
		else
			for (i = 7; i >= 0; i--)
				put({~b[i], b[i], ~b[i], b[i]}); // upper lines churn
	endtask
	// one framed command; ex adds clocks past the byte boundary
	task automatic frame(input logic [7:0] op, input logic wo,
		input logic wr, input int na, input logic [23:0] a, input int nd,
		input logic [7:0] d0, input int ex);
		int i;
		#3 o_cs_n = 1'b0; // odd offset keeps link phase apart
		#40 send(op, wo);
		for (i = na - 1; i >= 0; i--)
			send(a[i*8 +: 8], wr); // three bytes or none
		for (i = 0; i < nd; i++)
			send(d0 + 8'(i / 2), wr); // whole data bytes
		for (i = 0; i < ex; i++)
			put(~last_r);
		#40 o_cs_n = 1'b1; // rise on the boundary
		o_lines = ~last_r; // released lines hold no stale value
		#400;
	endtask
	initial
	begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_lines = 4'h0;
		last_r = 4'h0;
	end
endmodule
`default_nettype wire

// file: test_flash_cmd_seq.sv
// self-checking bench for the erase/program command sequencer
`default_nettype none
module test_flash_cmd_seq;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] WA = 8'h06, FM = 8'h68, SW = 8'h21, SU = 8'hb0;
	localparam logic [7:0] PW = 8'h02, QW = 8'h38, WW = 8'h60;
	logic [7:0] wops [4] = '{SW, 8'h52, 8'hd8, WW}; // wipe kinds 1 to 4
	logic clk = 1'b0, rst_n = 1'b0, qpi = 1'b0, qen = 1'b0, sch = 1'b0;
	logic srst = 1'b0, afail = 1'b0, rdy = 1'b0;
	logic [3:0] lvl = 4'h0;
	logic [255:0] lock = '0;
	wire cs_n, sclk, wv, wal, busy, wff, pff, susp, ws, pws, pdone;
	wire [3:0] lines;
	wire [7:0] fm;
	wire [2:0] kind;
	wire [23:0] adr;
	wire [255:0] mask;
	wire [15:0] wd;
	int num_errors = 0, total_checks = 0, cyc = 0, n_go = 0, n_susp = 0;
	int i, g, n_done = 0;
	logic [2:0] kind_s;
	logic [23:0] adr_s;
	logic [255:0] mask_s;
	logic [15:0] words [$]; // drained {offset, byte} words
	logic [7:0] pg [256]; // expected byte per page offset
	always #5 clk = ~clk;
	flash_cmd_seq #(.OP_SECTOR_WIPE(SW), // opcode 21, not the table's 20
		.SECTOR_WIPE_CYC(20), .HALF_WIPE_CYC(20), .LARGE_WIPE_CYC(20),
		.WHOLE_WIPE_CYC(20), .PAGE_WRITE_CYC(20)) i_dut (
		.i_core_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
		.i_quad_lines(lines), .i_qpi_mode(qpi), .i_quad_io_allow(qen),
		.i_protect_scheme_choice(sch), .i_level_protect_bits(lvl),
		.i_sector_lock_bits(lock), .i_soft_reset(srst), .i_array_fail(afail),
		.o_write_allow_latch(wal), .o_op_in_progress_flag(busy),
		.o_wipe_fail_flag(wff), .o_write_fail_flag(pff), .o_fmode_status(fm),
		.o_suspend_refused(susp), .o_wipe_start(ws), .o_wipe_kind(kind),
		.o_wipe_addr(adr), .o_wipe_skip_mask(mask), .o_wdata_valid(wv),
		.i_wdata_ready(rdy), .o_wdata(wd), .o_write_start(pws),
		.o_write_done(pdone));
	host_spi_model i_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_lines(lines));
	// drain side stalls for most of each 64-cycle stretch
	always @(negedge clk)
		rdy <= (cyc % 64) > 40;
	// records launches, refusals and drained words; cuts a hang
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (ws || pws)
		begin
			n_go <= n_go + 1;
			kind_s <= kind;
			adr_s <= adr;
			mask_s <= mask;
		end
		if (susp)
			n_susp <= n_susp + 1;
		if (pdone)
			n_done <= n_done + 1;
		if (wv && rdy)
			words.push_back(wd);
		if (cyc == 60000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// opcode-only frame in the current line mode
	task automatic op1(input logic [7:0] op);
		i_host.frame(op, qpi, qpi, 0, 24'h0, 0, 8'h0, 0);
	endtask
	// waits, bounded, until no cycle runs; ends on a falling edge
	task automatic idle();
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (busy !== 1'b0 && n < 2000);
		check("idle", n < 2000, 1'b1);
	endtask
	// write-allow frame, then the command frame, then the cycle
	task automatic cmd(input logic [7:0] op, input logic wr, input int na,
		input logic [23:0] a, input int nd, input int ex);
		op1(WA);
		check("latch set", wal, 1'b1);
		i_host.frame(op, qpi, wr, na, a, nd, 8'ha0, ex);
		idle();
	endtask
	// page write; offsets wrap, later bytes replace earlier ones
	task automatic page(input logic [7:0] op, input logic [7:0] st,
		input int nd);
		int k;
		words.delete();
		for (k = 0; k < nd; k++)
			pg[st + 8'(k)] = 8'ha0 + 8'(k / 2);
		cmd(op, qpi || op == QW, 3, {16'h0100, st}, nd, 0);
		repeat (70) @(negedge clk); // last words leave the fifo
		check("fifo empty", wv, 1'b0);
		check("wfail clr", pff, 1'b0);
		check("words", words.size(), nd > 256 ? 256 : nd);
		foreach (words[j])
			check("byte", words[j][7:0], pg[words[j][15:8]]);
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		check("fm reset", fm, 8'h00);
		check("busy reset", busy, 1'b0);
		i_host.frame(SW, 1'b0, 1'b0, 3, 24'h001000, 0, 8'h0, 0);
		check("no latch", n_go, 0);
		for (i = 0; i < 4; i++)
		begin
			qpi = i[0]; // odd passes run fully on four lines
			cmd(wops[i], qpi, i == 3 ? 0 : 3, 24'h3a5c7e, 0, 0);
			check("kind", kind_s, i + 1);
			check("sector", adr_s[23:12], 12'h3a5);
			check("latch clr", wal, 1'b0);
		end
		qpi = 1'b0;
		g = n_go;
		cmd(SW, 1'b0, 3, 24'h001000, 0, 1); // one clock too many
		cmd(PW, 1'b0, 3, 24'h001000, 0, 0); // no data byte
		check("boundary", n_go, g);
		lvl = 4'h2;
		cmd(SW, 1'b0, 3, 24'h001000, 0, 0);
		cmd(WW, 1'b0, 0, 24'h0, 0, 0);
		check("level", n_go, g);
		check("fail set", wff, 1'b1);
		lvl = 4'h0;
		cmd(SW, 1'b0, 3, 24'h001000, 0, 0);
		check("fail clr", wff, 1'b0);
		afail = 1'b1;
		cmd(SW, 1'b0, 3, 24'h020000, 0, 0);
		afail = 1'b0;
		check("array fail", wff, 1'b1);
		sch = 1'b1;
		lock[5] = 1'b1;
		g = n_go;
		cmd(SW, 1'b0, 3, 24'h005123, 0, 0);
		cmd(8'hd8, 1'b0, 3, 24'h00f000, 0, 0); // block holds sector 5
		check("locked", n_go, g);
		cmd(SW, 1'b0, 3, 24'h006000, 0, 0);
		cmd(8'hd8, 1'b0, 3, 24'h010000, 0, 0);
		cmd(WW, 1'b0, 0, 24'h0, 0, 0);
		check("unlocked", n_go, g + 3);
		check("skip", mask_s[16:0], 17'h0ffff);
		sch = 1'b0;
		lvl = 4'h1;
		cmd(PW, 1'b0, 3, 24'h000100, 1, 0);
		check("wfail set", pff, 1'b1);
		lvl = 4'h0;
		page(PW, 8'hfe, 3); // wraps inside the page
		qpi = 1'b1;
		page(PW, 8'h00, 258);
		qpi = 1'b0;
		g = n_go;
		cmd(QW, 1'b1, 3, 24'h000010, 1, 0);
		check("quad off", n_go, g);
		qen = 1'b1;
		page(QW, 8'h10, 2);
		check("done", n_done, 3);
		op1(WA);
		op1(FM);
		check("fm on", fm, 8'hff);
		op1(SU);
		check("suspend", n_susp, 1);
		i_host.frame(SW, 1'b0, 1'b0, 3, 24'h002000, 0, 8'h0, 0);
		idle();
		@(negedge clk);
		check("fm done", fm, 8'h00);
		op1(WA);
		op1(FM);
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		check("fm pin", fm, 8'h00);
		op1(WA);
		op1(FM);
		@(negedge clk);
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		check("fm soft", fm, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
